// ### common/sdbi_pkg.sv
// constants and types shared by the interbank burst interrupt logic
// Behaviour
// RULE1 - interrupted burst with auto precharge makes its bank start precharging
// RULE2 - a burst not interrupted by another bank runs to completion as started
// RULE3 - read interrupting read takes data bus CAS latency later, back to back
// RULE4 - write ends another bank's plain read at registration; controller masks one clock before
// RULE5 - read ends plain write at registration; last write word one clock earlier
// RULE6 - write ends plain write at registration; last old word on preceding clock
// RULE7 - read interrupting read with auto precharge: precharge starts at new read
// RULE8 - controller masks data two clocks before write interrupting read with auto precharge
// RULE9 - write interrupting read with auto precharge stops it; precharge same clock
// RULE10 - read interrupting write with auto precharge: precharge after write recovery
// RULE11 - write interrupting write with auto precharge: precharge after write recovery
// RULE12 - commands decoded from active-low select, row, column strobes and write enable
// RULE13 - auto precharge bank stays busy until precharge period ends, then idle
// RULE14 - controller tracks per bank whether the running burst has auto precharge
// RULE15 - controller waits recovery and precharge before activating an interrupted bank
package sdbi_pkg;

  // command codes {select, row strobe, column strobe, write enable}
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // address fields
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned COL_W = 8;
  localparam int unsigned ROW_W = 12;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned NBANK = 4;
  localparam int unsigned LEFT_W = 4;

  // defaults of the mode that software would otherwise load
  localparam int unsigned CAS_LAT_DEF = 2;
  localparam int unsigned BURST_LEN_DEF = 4;

  // timing, in its own unit and as clock counts
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned TRP_NS = 15;
  localparam int unsigned TWR_NS = 15;
  localparam int unsigned TRP_CYC_RAW = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TWR_CYC_RAW = (TWR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TRP_CYC = (TRP_CYC_RAW < 1) ? 1 : TRP_CYC_RAW;
  localparam int unsigned TWR_CYC = (TWR_CYC_RAW < 1) ? 1 : TWR_CYC_RAW;
  localparam int unsigned CNT_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_RD,
    ST_WR,
    ST_RD_AP,
    ST_WR_AP,
    ST_RECOVER,
    ST_PRECHARGE
  } sdbi_bank_st_t;

endpackage

// ### rtl/sdbi_bank.sv
// per-bank state machine with concurrent auto precharge
module sdbi_bank #(
  parameter int unsigned TWR_CYC = sdbi_pkg::TWR_CYC,
  parameter int unsigned TRP_CYC = sdbi_pkg::TRP_CYC,
  parameter int unsigned CNT_W = sdbi_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_act_i,
  input wire logic cmd_rd_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_pre_i,
  input wire logic ap_i,
  input wire logic other_i,
  input wire logic burst_end_i,
  output logic idle_o,
  output logic busy_o,
  output logic pre_start_o,
  output sdbi_pkg::sdbi_bank_st_t state_o
);

  if (TWR_CYC < 1 || TWR_CYC > (2 ** CNT_W)) begin : g_bad_twr
    $error("write recovery count does not fit the counter");
  end
  if (TRP_CYC < 1 || TRP_CYC > (2 ** CNT_W)) begin : g_bad_trp
    $error("precharge count does not fit the counter");
  end

  localparam int TWR_D = TWR_CYC;
  localparam int TRP_M1 = TRP_CYC - 1;

  typedef struct packed {
    sdbi_pkg::sdbi_bank_st_t st;
    logic [CNT_W-1:0] cnt;
    logic pst;
  } sdbi_bstate_t;

  sdbi_bstate_t state_reg;
  sdbi_bstate_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.pst = 1'b0;
    case (state_reg.st)
      sdbi_pkg::ST_IDLE: begin
        if (cmd_act_i) begin
          state_next.st = sdbi_pkg::ST_ACTIVE;
        end
      end
      sdbi_pkg::ST_ACTIVE, sdbi_pkg::ST_RD, sdbi_pkg::ST_WR: begin
        if (cmd_rd_i) begin
          state_next.st = ap_i ? sdbi_pkg::ST_RD_AP : sdbi_pkg::ST_RD;
        end else if (cmd_wr_i) begin
          state_next.st = ap_i ? sdbi_pkg::ST_WR_AP : sdbi_pkg::ST_WR;
        end else if (cmd_pre_i) begin
          state_next.st = sdbi_pkg::ST_PRECHARGE;
          state_next.cnt = CNT_W'(TRP_CYC - 1);
          state_next.pst = 1'b1;
        end else if (state_reg.st != sdbi_pkg::ST_ACTIVE && (other_i || burst_end_i)) begin
          state_next.st = sdbi_pkg::ST_ACTIVE;
        end
      end
      sdbi_pkg::ST_RD_AP: begin
        // precharge starts on the clock the interrupting command lands [RULE1] [RULE7] [RULE9]
        if (other_i || burst_end_i) begin
          state_next.st = sdbi_pkg::ST_PRECHARGE;
          state_next.cnt = CNT_W'(TRP_CYC - 1);
          state_next.pst = 1'b1;
        end
      end
      sdbi_pkg::ST_WR_AP: begin
        // recovery counted from the interrupting command [RULE1] [RULE10] [RULE11]
        if (other_i || burst_end_i) begin
          state_next.st = sdbi_pkg::ST_RECOVER;
          state_next.cnt = CNT_W'(TWR_CYC - 1);
        end
      end
      sdbi_pkg::ST_RECOVER: begin
        if (state_reg.cnt == '0) begin
          state_next.st = sdbi_pkg::ST_PRECHARGE;
          state_next.cnt = CNT_W'(TRP_CYC - 1);
          state_next.pst = 1'b1;
        end else begin
          state_next.cnt = state_reg.cnt - CNT_W'(1);
        end
      end
      sdbi_pkg::ST_PRECHARGE: begin
        // busy until the precharge period is over [RULE13]
        if (state_reg.cnt == '0) begin
          state_next.st = sdbi_pkg::ST_IDLE;
        end else begin
          state_next.cnt = state_reg.cnt - CNT_W'(1);
        end
      end
      default: begin
        state_next.st = sdbi_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_o = state_reg.st;
  assign idle_o = (state_reg.st == sdbi_pkg::ST_IDLE);
  assign busy_o = (state_reg.st == sdbi_pkg::ST_RD_AP) || (state_reg.st == sdbi_pkg::ST_WR_AP)
    || (state_reg.st == sdbi_pkg::ST_RECOVER) || (state_reg.st == sdbi_pkg::ST_PRECHARGE);
  assign pre_start_o = state_reg.pst;

  ap_start_a: assert property ( // [RULE1]
    @(posedge clk_i) disable iff (rst_i)
    ((state_o == sdbi_pkg::ST_RD_AP || state_o == sdbi_pkg::ST_WR_AP) && other_i)
    |=> (state_o == sdbi_pkg::ST_RECOVER || state_o == sdbi_pkg::ST_PRECHARGE))
    else $error("interrupted auto precharge bank did not start precharge");

  burst_keep_a: assert property ( // [RULE2]
    @(posedge clk_i) disable iff (rst_i)
    ((state_o == sdbi_pkg::ST_RD || state_o == sdbi_pkg::ST_WR || state_o == sdbi_pkg::ST_RD_AP
      || state_o == sdbi_pkg::ST_WR_AP) && !other_i && !burst_end_i && !cmd_rd_i && !cmd_wr_i
      && !cmd_pre_i)
    |=> $stable(state_o))
    else $error("burst state changed without cause");

  rd_ap_pre_a: assert property ( // [RULE7]
    @(posedge clk_i) disable iff (rst_i)
    (state_o == sdbi_pkg::ST_RD_AP && other_i) |=> (state_o == sdbi_pkg::ST_PRECHARGE && pre_start_o))
    else $error("read auto precharge not started at interrupt");

  wr_ap_rcv_a: assert property ( // [RULE10]
    @(posedge clk_i) disable iff (rst_i)
    (state_o == sdbi_pkg::ST_WR_AP && other_i)
    |=> (state_o == sdbi_pkg::ST_RECOVER) ##TWR_D (state_o == sdbi_pkg::ST_PRECHARGE && pre_start_o))
    else $error("write auto precharge not delayed by write recovery");

  pre_idle_a: assert property ( // [RULE13]
    @(posedge clk_i) disable iff (rst_i)
    pre_start_o |-> busy_o ##TRP_M1 (busy_o && !idle_o) ##1 idle_o)
    else $error("precharge period length wrong");

endmodule

// ### rtl/sdbi_core.sv
// device side of a four-bank synchronous dram: bursts, interbank interrupts, auto precharge
module sdbi_core #(
  parameter int unsigned CAS_LATENCY = sdbi_pkg::CAS_LAT_DEF,
  parameter int unsigned BURST_LEN = sdbi_pkg::BURST_LEN_DEF,
  parameter int unsigned TWR_CYC = sdbi_pkg::TWR_CYC,
  parameter int unsigned TRP_CYC = sdbi_pkg::TRP_CYC
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [sdbi_pkg::BANK_W-1:0] BA_I,
  input wire logic [sdbi_pkg::ROW_W-1:0] ADDR_I,
  input wire logic DQM_I,
  input wire logic [sdbi_pkg::DQ_W-1:0] DQ_I,
  output logic [sdbi_pkg::DQ_W-1:0] DQ_O,
  output logic DQ_OE_O,
  output logic ARR_RD_O,
  output logic [sdbi_pkg::BANK_W-1:0] ARR_RD_BANK_O,
  output logic [sdbi_pkg::ROW_W-1:0] ARR_RD_ROW_O,
  output logic [sdbi_pkg::COL_W-1:0] ARR_RD_COL_O,
  input wire logic [sdbi_pkg::DQ_W-1:0] ARR_RDATA_I,
  output logic ARR_WR_O,
  output logic [sdbi_pkg::BANK_W-1:0] ARR_WR_BANK_O,
  output logic [sdbi_pkg::ROW_W-1:0] ARR_WR_ROW_O,
  output logic [sdbi_pkg::COL_W-1:0] ARR_WR_COL_O,
  output logic [sdbi_pkg::DQ_W-1:0] ARR_WDATA_O,
  output logic [sdbi_pkg::NBANK-1:0] BANK_IDLE_O,
  output logic [sdbi_pkg::NBANK-1:0] BANK_BUSY_O,
  output logic [sdbi_pkg::NBANK-1:0] PRE_START_O,
  output logic BURST_RD_O,
  output logic BURST_WR_O,
  output logic [sdbi_pkg::BANK_W-1:0] BURST_BANK_O,
  output logic CMD_ILLEGAL_O
);

  if (CAS_LATENCY != 2 && CAS_LATENCY != 3) begin : g_bad_cl
    $error("CAS latency must be 2 or 3");
  end
  if (BURST_LEN != 1 && BURST_LEN != 2 && BURST_LEN != 4 && BURST_LEN != 8) begin : g_bad_bl
    $error("burst length must be 1, 2, 4 or 8");
  end

  localparam int unsigned CL = CAS_LATENCY;
  localparam int unsigned BW = sdbi_pkg::BANK_W;
  localparam int unsigned CW = sdbi_pkg::COL_W;
  localparam int unsigned RW = sdbi_pkg::ROW_W;
  localparam int unsigned DW = sdbi_pkg::DQ_W;
  localparam int unsigned LW = sdbi_pkg::LEFT_W;
  localparam int unsigned NB = sdbi_pkg::NBANK;
  localparam logic [CW-1:0] WRAP = CW'(BURST_LEN - 1);

  typedef struct packed {
    logic [CL-1:0] pv;
    logic [CL-1:0][BW-1:0] pb;
    logic [CL-1:0][CW-1:0] pc;
    logic [1:0] dqm_d;
    logic rd_on;
    logic wr_on;
    logic [BW-1:0] bb;
    logic [CW-1:0] bc;
    logic [LW-1:0] left;
    logic [NB-1:0][RW-1:0] row;
    logic oe;
    logic [DW-1:0] dq;
    logic aw;
    logic [BW-1:0] awb;
    logic [RW-1:0] awr;
    logic [CW-1:0] awc;
    logic [DW-1:0] awd;
    logic ill;
  } sdbi_core_t;

  sdbi_core_t state_reg;
  sdbi_core_t state_next;

  logic [3:0] cmd_code;
  logic cmd_rd;
  logic cmd_wr;
  logic cmd_act;
  logic cmd_pre;
  logic pre_all;
  logic auto_pre;
  logic [CW-1:0] cmd_col;
  logic burst_last;
  logic [NB-1:0] bank_idle;
  logic [NB-1:0] bank_busy;
  logic [NB-1:0] own;
  logic illegal;

  // sequential wrap inside the burst-length block; length one keeps the column
  function automatic logic [CW-1:0] next_col(input logic [CW-1:0] c);
    next_col = (c & ~WRAP) | ((c + CW'(1)) & WRAP);
  endfunction

  // select high never matches a code, so it inhibits [RULE12]
  assign cmd_code = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
  assign cmd_rd = (cmd_code == sdbi_pkg::CMD_READ);
  assign cmd_wr = (cmd_code == sdbi_pkg::CMD_WRITE);
  assign cmd_act = (cmd_code == sdbi_pkg::CMD_ACTIVE);
  assign cmd_pre = (cmd_code == sdbi_pkg::CMD_PRECHARGE);
  assign auto_pre = ADDR_I[sdbi_pkg::AP_BIT];
  assign pre_all = cmd_pre && ADDR_I[sdbi_pkg::AP_BIT];
  assign cmd_col = ADDR_I[CW-1:0];

  // last word of the running burst goes out on this edge
  assign burst_last = (state_reg.rd_on || state_reg.wr_on) && (state_reg.left <= LW'(1));

  // busy banks accept only nop; idle banks take no column command
  always_comb begin
    illegal = 1'b0;
    for (int b = 0; b < NB; b++) begin
      if (own[b] && bank_busy[b] && (cmd_act || cmd_rd || cmd_wr || cmd_pre)) begin
        illegal = 1'b1;
      end
      if (own[b] && cmd_act && !bank_idle[b]) begin
        illegal = 1'b1;
      end
      if (own[b] && (cmd_rd || cmd_wr) && bank_idle[b]) begin
        illegal = 1'b1;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.pv = {state_reg.pv[CL-2:0], 1'b0};
    state_next.pb = {state_reg.pb[CL-2:0], {BW{1'b0}}};
    state_next.pc = {state_reg.pc[CL-2:0], {CW{1'b0}}};
    state_next.dqm_d = {state_reg.dqm_d[0], DQM_I};
    state_next.aw = 1'b0;
    state_next.ill = illegal;
    // mask sampled two clocks earlier blanks the read word [RULE4] [RULE8]
    state_next.oe = state_reg.pv[CL-1] && !state_reg.dqm_d[1];
    if (state_reg.pv[CL-1]) begin
      state_next.dq = ARR_RDATA_I;
    end
    if (cmd_act) begin
      state_next.row[BA_I] = ADDR_I;
    end
    // burst keeps going as started until something cuts it [RULE2]
    if ((state_reg.rd_on || state_reg.wr_on) && state_reg.left != '0) begin
      state_next.bc = next_col(state_reg.bc);
      state_next.left = state_reg.left - LW'(1);
      if (state_reg.rd_on) begin
        state_next.pv[0] = 1'b1;
        state_next.pb[0] = state_reg.bb;
        state_next.pc[0] = next_col(state_reg.bc);
      end
      if (state_reg.wr_on) begin
        state_next.aw = !DQM_I;
        state_next.awb = state_reg.bb;
        state_next.awr = state_reg.row[state_reg.bb];
        state_next.awc = next_col(state_reg.bc);
        state_next.awd = DQ_I;
      end
    end
    if (burst_last) begin
      state_next.rd_on = 1'b0;
      state_next.wr_on = 1'b0;
    end
    if (cmd_rd) begin
      // old reads still in the pipe drain first, giving back to back data [RULE3] [RULE7]
      // a write burst stops here; its last word was the previous clock [RULE5] [RULE10]
      state_next.rd_on = 1'b1;
      state_next.wr_on = 1'b0;
      state_next.bb = BA_I;
      state_next.bc = cmd_col;
      state_next.left = LW'(BURST_LEN - 1);
      state_next.pv[0] = 1'b1;
      state_next.pb[0] = BA_I;
      state_next.pc[0] = cmd_col;
      state_next.aw = 1'b0;
    end else if (cmd_wr) begin
      // a read is cut at once, words in flight are dropped [RULE4] [RULE9]
      // a write burst hands over; this clock carries the new word [RULE6] [RULE11]
      state_next.wr_on = 1'b1;
      state_next.rd_on = 1'b0;
      state_next.bb = BA_I;
      state_next.bc = cmd_col;
      state_next.left = LW'(BURST_LEN - 1);
      state_next.pv = '0;
      state_next.oe = 1'b0;
      state_next.aw = !DQM_I;
      state_next.awb = BA_I;
      state_next.awr = state_reg.row[BA_I];
      state_next.awc = cmd_col;
      state_next.awd = DQ_I;
    end else if (cmd_pre && (pre_all || BA_I == state_reg.bb)) begin
      state_next.rd_on = 1'b0;
      state_next.wr_on = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic other;
    logic bend;
    assign own[b] = (BA_I == BW'(b));
    // a column command to another bank is what interrupts this one
    assign other = (cmd_rd || cmd_wr) && !own[b];
    assign bend = burst_last && (state_reg.bb == BW'(b)) && !cmd_rd && !cmd_wr;
    sdbi_bank #(
      .TWR_CYC(TWR_CYC),
      .TRP_CYC(TRP_CYC),
      .CNT_W(sdbi_pkg::CNT_W)
    ) u_bank (
      .clk_i(CLK_SYS_I),
      .rst_i(RESET_I),
      .cmd_act_i(cmd_act && own[b]),
      .cmd_rd_i(cmd_rd && own[b]),
      .cmd_wr_i(cmd_wr && own[b]),
      .cmd_pre_i(cmd_pre && (own[b] || pre_all)),
      .ap_i(auto_pre),
      .other_i(other),
      .burst_end_i(bend),
      .idle_o(bank_idle[b]),
      .busy_o(bank_busy[b]),
      .pre_start_o(PRE_START_O[b]),
      .state_o()
    );
  end

  assign BANK_IDLE_O = bank_idle;
  assign BANK_BUSY_O = bank_busy;
  assign DQ_O = state_reg.dq;
  assign DQ_OE_O = state_reg.oe;
  assign ARR_RD_O = state_reg.pv[CL-1];
  assign ARR_RD_BANK_O = state_reg.pb[CL-1];
  assign ARR_RD_ROW_O = state_reg.row[state_reg.pb[CL-1]];
  assign ARR_RD_COL_O = state_reg.pc[CL-1];
  assign ARR_WR_O = state_reg.aw;
  assign ARR_WR_BANK_O = state_reg.awb;
  assign ARR_WR_ROW_O = state_reg.awr;
  assign ARR_WR_COL_O = state_reg.awc;
  assign ARR_WDATA_O = state_reg.awd;
  assign BURST_RD_O = state_reg.rd_on;
  assign BURST_WR_O = state_reg.wr_on;
  assign BURST_BANK_O = state_reg.bb;
  assign CMD_ILLEGAL_O = state_reg.ill;

  rd_data_a: assert property ( // [RULE3]
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (ARR_RD_O && !state_reg.dqm_d[1] && !cmd_wr) |=> (DQ_OE_O && DQ_O == $past(ARR_RDATA_I)))
    else $error("read word not driven after array read");

  rd_chain_a: assert property ( // [RULE3]
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_reg.rd_on && cmd_rd) |=> (state_reg.pv[0] && state_reg.pb[0] == $past(BA_I)
      && state_reg.rd_on && state_reg.bb == $past(BA_I)))
    else $error("interrupting read did not take over the burst");

  wr_cut_rd_a: assert property ( // [RULE4]
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    cmd_wr |=> (!DQ_OE_O && !ARR_RD_O && !BURST_RD_O))
    else $error("read data still driven after write");

  rd_cut_wr_a: assert property ( // [RULE5]
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_reg.wr_on && cmd_rd) |=> (!ARR_WR_O && !BURST_WR_O))
    else $error("write word taken on the read clock");

  wr_cut_wr_a: assert property ( // [RULE6]
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_reg.wr_on && cmd_wr && !DQM_I) |=> (ARR_WR_O && ARR_WR_BANK_O == $past(BA_I)
      && ARR_WR_COL_O == $past(cmd_col)))
    else $error("new write did not take its first word");

  inhibit_a: assert property ( // [RULE12]
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (CS_N_I && !state_reg.wr_on && !state_reg.rd_on) |=> (!ARR_WR_O && !BURST_RD_O && !BURST_WR_O))
    else $error("inhibited command had an effect");

endmodule

// ### verification/sdbi_ctrl_model.sv
// memory controller model: drives the command, mask and write data pins
module sdbi_ctrl_model #(
  parameter int unsigned GUARD = 16
) (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [1:0] ba_o,
  output logic [11:0] addr_o,
  output logic dqm_o,
  output logic [15:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ap_seen = 4'h0;

  initial begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = sdbi_pkg::CMD_NOP;
    ba_o = 2'h0;
    addr_o = 12'h000;
    dqm_o = 1'b0;
    dq_o = 16'h0000;
  end

  // one command per call, changed at the falling edge so the rising edge sees it settled
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic m, input logic [15:0] d);
    @(negedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = c;
    ba_o = b;
    addr_o = a;
    dqm_o = m;
    dq_o = d;
    if (c == sdbi_pkg::CMD_READ || c == sdbi_pkg::CMD_WRITE) begin
      ap_seen[b] = a[10];
    end
  endtask

  // released data lines flip every cycle so a stale word never looks valid
  task automatic nop(input logic m);
    cmd(sdbi_pkg::CMD_NOP, 2'h0, 12'h000, m, ~dq_o);
  endtask

  // coarse guard instead of exact recovery sums: slower, but never early
  task automatic activate(input logic [1:0] b, input logic [11:0] row);
    if (ap_seen[b]) begin
      repeat (GUARD) nop(1'b0);
    end
    ap_seen[b] = 1'b0;
    cmd(sdbi_pkg::CMD_ACTIVE, b, row, 1'b0, ~dq_o);
  endtask
endmodule

// ### verification/sdbi_core_bench.sv
// self-checking bench for the interbank burst interrupt logic
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module sdbi_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TW = sdbi_pkg::TWR_CYC;
  localparam int unsigned TP = sdbi_pkg::TRP_CYC;
  localparam logic [3:0] RD = sdbi_pkg::CMD_READ;
  localparam logic [3:0] WR = sdbi_pkg::CMD_WRITE;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  int n_mismatch = 0;
  int checked = 0;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic dqm;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [15:0] ctrl_dq;
  logic [15:0] dq_rd;
  logic dq_oe;
  logic arr_rd;
  logic [1:0] arr_rd_bank;
  logic [11:0] arr_rd_row;
  logic [7:0] arr_rd_col;
  logic arr_wr;
  logic [1:0] arr_wr_bank;
  logic [7:0] arr_wr_col;
  logic [15:0] arr_wdata;
  logic [3:0] bank_idle;
  logic [3:0] pre_start;
  logic cmd_illegal;
  logic [11:0] arr_wr_row;
  logic [3:0] bank_busy;
  logic burst_rd;
  logic burst_wr;
  logic [1:0] burst_bank;
  // device owns the data lines only while it drives them
  wire [15:0] dq_bus = dq_oe ? dq_rd : ctrl_dq;
  // array model: the word names its own bank, row and column
  wire [15:0] arr_rdata = {arr_rd_bank, arr_rd_row[5:0], arr_rd_col};

  sdbi_ctrl_model ctrl (.clk_i(clk_sys), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
    .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .dqm_o(dqm), .dq_o(ctrl_dq));

  // default parameters: cas latency 2, burst length 4, package timing counts
  sdbi_core dut (
    .CLK_SYS_I(clk_sys), .RESET_I(reset), .CS_N_I(cs_n), .RAS_N_I(ras_n), .CAS_N_I(cas_n),
    .WE_N_I(we_n), .BA_I(ba), .ADDR_I(addr), .DQM_I(dqm), .DQ_I(dq_bus), .DQ_O(dq_rd),
    .DQ_OE_O(dq_oe), .ARR_RD_O(arr_rd), .ARR_RD_BANK_O(arr_rd_bank),
    .ARR_RD_ROW_O(arr_rd_row), .ARR_RD_COL_O(arr_rd_col), .ARR_RDATA_I(arr_rdata),
    .ARR_WR_O(arr_wr), .ARR_WR_BANK_O(arr_wr_bank), .ARR_WR_ROW_O(arr_wr_row),
    .ARR_WR_COL_O(arr_wr_col), .ARR_WDATA_O(arr_wdata), .BANK_IDLE_O(bank_idle),
    .BANK_BUSY_O(bank_busy), .PRE_START_O(pre_start), .BURST_RD_O(burst_rd),
    .BURST_WR_O(burst_wr), .BURST_BANK_O(burst_bank), .CMD_ILLEGAL_O(cmd_illegal));

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [11:0] ca(input logic ap, input logic [7:0] c);
    return {1'b0, ap, 2'h0, c};
  endfunction

  task automatic chk_rd(input logic [1:0] b, input logic [7:0] c);
    `CHK(dq_oe, 1'b1)
    `CHK(dq_rd, {b, 6'h20 + {4'h0, b}, c})
  endtask

  // fresh device for each case: all banks idle, then one row opened in every bank
  task automatic start();
    @(negedge clk_sys);
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    for (int b = 0; b < 4; b++) begin
      ctrl.activate(2'(b), 12'h0A0 + 12'(b));
    end
  endtask

  // read in bank 0 cut by read in bank 1 at two edges later; schedule assumes TP of 4
  task automatic rd_rd(input logic ap);
    start();
    ctrl.cmd(RD, 2'h0, ca(ap, 8'h00), 1'b0, 16'h0000);
    ctrl.nop(1'b0);
    ctrl.cmd(RD, 2'h1, ca(1'b0, 8'h06), 1'b0, 16'h0000);
    ctrl.nop(1'b0);
    chk_rd(2'h0, 8'h00);
    `CHK(pre_start[0], ap)
    `CHK(bank_busy[0], ap)
    `CHK(burst_rd, 1'b1)
    `CHK(burst_bank, 2'h1)
    `CHK(arr_rd, 1'b1)
    ctrl.nop(1'b0);
    chk_rd(2'h0, 8'h01);
    ctrl.nop(1'b0);
    chk_rd(2'h1, 8'h06);
    ctrl.nop(1'b0);
    chk_rd(2'h1, 8'h07);
    `CHK(bank_idle[0], 1'b0)
    ctrl.nop(1'b0);
    chk_rd(2'h1, 8'h04);
    `CHK(bank_idle[0], ap)
  endtask

  // read in bank 0 cut by write in bank 1, mask raised ahead of the write
  task automatic rd_wr(input logic ap);
    start();
    ctrl.cmd(RD, 2'h0, ca(ap, 8'h00), ap, 16'h0000);
    ctrl.nop(1'b1);
    ctrl.cmd(WR, 2'h1, ca(1'b0, 8'h10), 1'b0, 16'h5A01);
    ctrl.cmd(sdbi_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0, 16'h5A02);
    `CHK(dq_oe, 1'b0)
    `CHK(arr_wr, 1'b1)
    `CHK(arr_wr_bank, 2'h1)
    `CHK(arr_wdata, 16'h5A01)
    `CHK(arr_rd, 1'b0)
    `CHK(burst_rd, 1'b0)
    `CHK(burst_wr, 1'b1)
    `CHK(bank_busy[0], ap)
    `CHK(pre_start[0], ap)
    ctrl.nop(1'b0);
    `CHK(dq_oe, 1'b0)
    `CHK(arr_wdata, 16'h5A02)
  endtask

  // write in bank 0 cut at its third edge by a read or a write to bank 1
  task automatic wr_int(input logic ap, input logic rd2);
    start();
    ctrl.cmd(WR, 2'h0, ca(ap, 8'h00), 1'b0, 16'hC000);
    ctrl.cmd(sdbi_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0, 16'hC001);
    `CHK(arr_wdata, 16'hC000)
    ctrl.cmd(rd2 ? RD : WR, 2'h1, ca(1'b0, 8'h00), 1'b0, 16'hC0F2);
    `CHK(arr_wr_col, 8'h01)
    `CHK(arr_wdata, 16'hC001)
    `CHK(arr_wr_row, 12'h0A0)
    ctrl.cmd(sdbi_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0, 16'hC0F3);
    `CHK(arr_wr, !rd2)
    `CHK(burst_wr, !rd2)
    `CHK(burst_rd, rd2)
    `CHK(bank_busy[0], ap)
    if (!rd2) begin
      `CHK(arr_wr_bank, 2'h1)
      `CHK(arr_wdata, 16'hC0F2)
    end
    for (int i = 3; i <= 2 + TW; i++) begin
      ctrl.cmd(sdbi_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0, 16'hC0F0 + 16'(i));
      if (i == 4 && rd2) chk_rd(2'h1, 8'h00);
      `CHK(pre_start[0], (i == 2 + TW) ? ap : 1'b0)
    end
  endtask

  // read with auto precharge in bank 2 while bank 3 is precharged: no cut
  task automatic rd_nat();
    start();
    ctrl.cmd(RD, 2'h2, ca(1'b1, 8'h0E), 1'b0, 16'h0000);
    ctrl.cmd(sdbi_pkg::CMD_PRECHARGE, 2'h3, 12'h000, 1'b0, 16'h0000);
    // activate into a precharging bank is flagged, not obeyed
    ctrl.cmd(sdbi_pkg::CMD_ACTIVE, 2'h3, 12'h0B3, 1'b0, 16'h0000);
    `CHK(pre_start[3], 1'b1)
    for (int i = 0; i < 4; i++) begin
      ctrl.nop(1'b0);
      chk_rd(2'h2, {6'h03, 2'(2 + i)});
      `CHK(cmd_illegal, (i == 0))
    end
    for (int i = 0; i < 4 * TP && bank_idle[2] !== 1'b1; i++) ctrl.nop(1'b0);
    `CHK(bank_idle, 4'hC)
    `CHK(cmd_illegal, 1'b0)
    // read pattern with select high must do nothing
    ctrl.cmd(4'hD, 2'h0, ca(1'b0, 8'h00), 1'b0, 16'h0000);
    ctrl.nop(1'b0);
    `CHK(burst_rd, 1'b0)
    `CHK(bank_busy, 4'h0)
    ctrl.nop(1'b0);
    `CHK(arr_rd, 1'b0)
  endtask

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    rd_rd(1'b0);
    rd_rd(1'b1);
    rd_wr(1'b0);
    rd_wr(1'b1);
    for (int k = 0; k < 4; k++) begin
      wr_int(k[1], k[0]);
    end
    rd_nat();
    print_verdict();
  end

  // whole run needs well under 1500 cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end
endmodule
